/* hdl/udrl_defines.vh */
`ifndef UDRL_DEFINES_VH
`define UDRL_DEFINES_VH
// ============================================================
// register byte offsets
`define UDRL_ADDR_DATA      8'h00
`define UDRL_ADDR_FCTL      8'h04
`define UDRL_ADDR_MCTL      8'h08
`define UDRL_ADDR_STAT      8'h0C
`define UDRL_ADDR_DIV       8'h10
// ============================================================
// register indices returned by the decoder
`define UDRL_SEL_NONE       3'h0
`define UDRL_SEL_DATA       3'h1
`define UDRL_SEL_FCTL       3'h2
`define UDRL_SEL_MCTL       3'h3
`define UDRL_SEL_STAT       3'h4
`define UDRL_SEL_DIV        3'h5
// ============================================================
// field positions
`define UDRL_FCTL_FIFO_EN   0
`define UDRL_FCTL_RX_CLR    1
`define UDRL_FCTL_TX_CLR    2
`define UDRL_FCTL_DMA_MODE  3
`define UDRL_FCTL_TRIG_LO   6
`define UDRL_FCTL_TRIG_HI   7
`define UDRL_MCTL_RTS       1
`define UDRL_MCTL_LOOP      4
// ============================================================
// reset values
`define UDRL_FCTL_RESET     8'h00
`define UDRL_MCTL_RESET     8'h00
`define UDRL_DIV_RESET      16'h0010
// ============================================================
// receive trigger levels, in characters
`define UDRL_TRIG_LVL0      5'h01
`define UDRL_TRIG_LVL1      5'h04
`define UDRL_TRIG_LVL2      5'h08
`define UDRL_TRIG_LVL3      5'h0E
// ============================================================
// fifo shape
`define UDRL_FIFO_WIDTH     8
`define UDRL_FIFO_DEPTH     16
`define UDRL_FIFO_AW        4
// ============================================================
// timing
`define UDRL_CLK_PERIOD_NS  5
`define UDRL_TOUT_NS        20000
`define UDRL_TOUT_CYCLES    (`UDRL_TOUT_NS / `UDRL_CLK_PERIOD_NS)
`endif

/* hdl/udrl_fifo.v */
`timescale 1ns/10ps
// ============================================================
// synchronous fifo with valid/ready on both sides
module udrl_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clk,
    input  wire             rstn,
    input  wire             en,
    input  wire             flush,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data,
    output wire [AW:0]      count
);
    reg  [WIDTH-1:0] mem [0:DEPTH-1];
    reg  [AW-1:0]    wr_ptr;
    reg  [AW-1:0]    rd_ptr;
    reg  [AW:0]      fill;
    wire             push;
    wire             pop;

    assign in_ready  = (fill != DEPTH[AW:0]);
    assign out_valid = (fill != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr];
    assign count     = fill;
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @(posedge clk) begin
        if (en && push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            fill   <= {(AW+1){1'b0}};
        end else if (en) begin
            if (flush) begin
                wr_ptr <= {AW{1'b0}};
                rd_ptr <= {AW{1'b0}};
                fill   <= {(AW+1){1'b0}};
            end else begin
                if (push) begin
                    wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
                end
                if (pop) begin
                    rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
                end
                if (push && !pop) begin
                    fill <= fill + {{AW{1'b0}}, 1'b1};
                end else if (pop && !push) begin
                    fill <= fill - {{AW{1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule // udrl_fifo

/* hdl/udrl_top.v */
`timescale 1ns/10ps
`include "udrl_defines.vh"

module udrl_top (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        ce,
    input  wire        hsel,
    input  wire [7:0]  haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output reg  [31:0] hrdata,
    input  wire        pin_chip_select,
    input  wire        write_strobe_low_active_n,
    input  wire        write_strobe_high_active,
    input  wire [2:0]  pin_addr,
    input  wire [7:0]  pin_data,
    input  wire [7:0]  rx_char_data,
    input  wire        rx_char_valid,
    output wire        rx_char_ready,
    input  wire        serial_line_in,
    output reg         serial_line_out,
    output reg         rts_n,
    output wire        rx_dma_request_n,
    output wire        tx_dma_request_n
);
    localparam TX_IDLE  = 1'b0;
    localparam TX_SHIFT = 1'b1;
    localparam integer TOUT_INT  = `UDRL_TOUT_CYCLES;
    localparam [12:0] TOUT_LIMIT = TOUT_INT[12:0];
    localparam [7:0]  FCTL_RST   = `UDRL_FCTL_RESET;
    localparam [7:0]  MCTL_RST   = `UDRL_MCTL_RESET;
    localparam [14:0] SYNC_RST   = 15'h4002;

    function [2:0] reg_sel;
        input [7:0] a;
        begin
            case (a)
                `UDRL_ADDR_DATA: reg_sel = `UDRL_SEL_DATA;
                `UDRL_ADDR_FCTL: reg_sel = `UDRL_SEL_FCTL;
                `UDRL_ADDR_MCTL: reg_sel = `UDRL_SEL_MCTL;
                `UDRL_ADDR_STAT: reg_sel = `UDRL_SEL_STAT;
                `UDRL_ADDR_DIV:  reg_sel = `UDRL_SEL_DIV;
                default:         reg_sel = `UDRL_SEL_NONE;
            endcase
        end
    endfunction

    // ============================================================
    // pin synchronisers
    wire [14:0] sync_in;
    reg  [14:0] sync_a;
    reg  [14:0] sync_b;
    assign sync_in = {serial_line_in, pin_data, pin_addr, write_strobe_high_active,
                      write_strobe_low_active_n, pin_chip_select};
    genvar gi;
    generate
        for (gi = 0; gi < 15; gi = gi + 1) begin : g_sync
            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    sync_a[gi] <= SYNC_RST[gi];
                    sync_b[gi] <= SYNC_RST[gi];
                end else if (ce) begin
                    sync_a[gi] <= sync_in[gi];
                    sync_b[gi] <= sync_a[gi];
                end
            end
        end
    endgenerate

    wire       cs_s    = sync_b[0];
    wire       strb_on = ~sync_b[1] | sync_b[2];
    wire [2:0] paddr_s = sync_b[5:3];
    wire [7:0] pdata_s = sync_b[13:6];
    wire       sin_s   = sync_b[14];
    reg        strb_prev;
    reg        cs_prev;
    wire       pin_wr  = strb_prev & ~strb_on & cs_prev;

    // ============================================================
    // registers and fifo wiring
    reg         fifo_en;
    reg         dma_mode;
    reg  [1:0]  trig_sel;
    reg         rts_bit;
    reg         loop_bit;
    reg  [15:0] divisor;
    reg         rx_flush;
    reg         tx_flush;
    reg         dp_valid;
    reg         dp_write;
    reg  [7:0]  dp_addr;
    wire        rx_in_ready;
    wire        rx_out_valid;
    wire [7:0]  rx_out_data;
    wire [4:0]  rx_count;
    wire        tx_in_ready;
    wire        tx_out_valid;
    wire [7:0]  tx_out_data;
    wire [4:0]  tx_count;
    wire        tx_out_ready;

    wire multi  = fifo_en & dma_mode;
    wire tx_space = fifo_en ? tx_in_ready : (tx_count == 5'h00);
    assign rx_char_ready = fifo_en ? rx_in_ready : (rx_count == 5'h00);

    // ============================================================
    // ahb-lite slave
    wire ahb_acc = hsel & htrans[1] & hready;
    wire stall   = dp_valid & dp_write & (reg_sel(dp_addr) == `UDRL_SEL_DATA) & ~tx_space;
    wire ahb_wr  = dp_valid & dp_write & ~stall;
    wire rd_go   = ahb_acc & ~hwrite;
    assign hreadyout = ~stall;
    assign hresp     = 1'b0;

    wire        wr_go   = ahb_wr | pin_wr;
    wire [7:0]  wr_addr = ahb_wr ? dp_addr : {3'b000, paddr_s, 2'b00};
    wire [15:0] wr_data = ahb_wr ? hwdata[15:0] : {8'h00, pdata_s};
    wire [2:0]  wr_sel  = reg_sel(wr_addr);
    wire [2:0]  rd_sel  = reg_sel(haddr);
    wire        tx_push = wr_go & (wr_sel == `UDRL_SEL_DATA) & tx_space;
    wire        rx_pop  = rd_go & (rd_sel == `UDRL_SEL_DATA) & rx_out_valid;

    // ============================================================
    // character timeout
    reg  [12:0] tout_cnt;
    wire        rx_push = rx_char_valid & rx_char_ready;
    wire        timeout = (tout_cnt == TOUT_LIMIT);

    // ============================================================
    // dma request state
    reg  [4:0]  trig_lvl;
    reg         rx_req;
    reg         tx_req;

    always @* begin
        case (trig_sel)
            2'h0:    trig_lvl = `UDRL_TRIG_LVL0;
            2'h1:    trig_lvl = `UDRL_TRIG_LVL1;
            2'h2:    trig_lvl = `UDRL_TRIG_LVL2;
            default: trig_lvl = `UDRL_TRIG_LVL3;
        endcase
    end

    assign rx_dma_request_n = multi ? ~rx_req : (rx_count == 5'h00);
    assign tx_dma_request_n = multi ? ~tx_req : (tx_count != 5'h00);

    wire [31:0] stat_val = {19'h00000, rx_count, 3'h0, sin_s, timeout,
                            ~tx_space, (tx_count == 5'h00), rx_out_valid};

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid  <= 1'b0;
            dp_write  <= 1'b0;
            dp_addr   <= 8'h00;
            hrdata    <= 32'h00000000;
            fifo_en   <= FCTL_RST[`UDRL_FCTL_FIFO_EN];
            dma_mode  <= FCTL_RST[`UDRL_FCTL_DMA_MODE];
            trig_sel  <= FCTL_RST[`UDRL_FCTL_TRIG_HI:`UDRL_FCTL_TRIG_LO];
            rts_bit   <= MCTL_RST[`UDRL_MCTL_RTS];
            loop_bit  <= MCTL_RST[`UDRL_MCTL_LOOP];
            divisor   <= `UDRL_DIV_RESET;
            rx_flush  <= 1'b0;
            tx_flush  <= 1'b0;
            strb_prev <= 1'b0;
            cs_prev   <= 1'b0;
            rts_n     <= 1'b1;
            tout_cnt  <= 13'h0000;
            rx_req    <= 1'b0;
            tx_req    <= 1'b0;
        end else if (ce) begin
            strb_prev <= strb_on;
            cs_prev   <= cs_s;
            if (hready) begin
                dp_valid <= ahb_acc;
                dp_write <= hwrite;
                dp_addr  <= haddr;
            end
            if (rd_go) begin
                case (rd_sel)
                    `UDRL_SEL_DATA: hrdata <= rx_out_valid ? {24'h000000, rx_out_data} : 32'h00000000;
                    `UDRL_SEL_FCTL: hrdata <= {24'h000000, trig_sel, 2'b00, dma_mode, 2'b00, fifo_en};
                    `UDRL_SEL_MCTL: hrdata <= {27'h0000000, loop_bit, 2'b00, rts_bit, 1'b0};
                    `UDRL_SEL_STAT: hrdata <= stat_val;
                    `UDRL_SEL_DIV:  hrdata <= {16'h0000, divisor};
                    default:        hrdata <= 32'h00000000;
                endcase
            end
            rx_flush <= 1'b0;
            tx_flush <= 1'b0;
            if (wr_go) begin
                case (wr_sel)
                    `UDRL_SEL_FCTL: begin
                        fifo_en  <= wr_data[`UDRL_FCTL_FIFO_EN];
                        dma_mode <= wr_data[`UDRL_FCTL_DMA_MODE];
                        trig_sel <= wr_data[`UDRL_FCTL_TRIG_HI:`UDRL_FCTL_TRIG_LO];
                        rx_flush <= wr_data[`UDRL_FCTL_RX_CLR];
                        tx_flush <= wr_data[`UDRL_FCTL_TX_CLR];
                    end
                    `UDRL_SEL_MCTL: begin
                        rts_bit  <= wr_data[`UDRL_MCTL_RTS];
                        loop_bit <= wr_data[`UDRL_MCTL_LOOP];
                    end
                    `UDRL_SEL_DIV: begin
                        divisor  <= wr_data;
                    end
                    default: begin
                    end
                endcase
            end
            rts_n <= ~(rts_bit & ~loop_bit);
            if (rx_count == 5'h00 || rx_push || rx_pop || rx_flush) begin
                tout_cnt <= 13'h0000;
            end else if (!timeout) begin
                tout_cnt <= tout_cnt + 13'h0001;
            end
            if (rx_count == 5'h00 || rx_flush) begin
                rx_req <= 1'b0;
            end else if (rx_count >= trig_lvl || timeout) begin
                rx_req <= 1'b1;
            end
            if (tx_count == 5'h00) begin
                tx_req <= 1'b1;
            end else if (!tx_in_ready) begin
                tx_req <= 1'b0;
            end
        end
    end

    // ============================================================
    // fifos
    udrl_fifo #(
        .WIDTH (`UDRL_FIFO_WIDTH),
        .DEPTH (`UDRL_FIFO_DEPTH),
        .AW    (`UDRL_FIFO_AW)
    ) u_rx_fifo (
        .clk       (hclk),
        .rstn      (hresetn),
        .en        (ce),
        .flush     (rx_flush),
        .in_valid  (rx_char_valid & rx_char_ready),
        .in_ready  (rx_in_ready),
        .in_data   (rx_char_data),
        .out_valid (rx_out_valid),
        .out_ready (rx_pop),
        .out_data  (rx_out_data),
        .count     (rx_count)
    );

    udrl_fifo #(
        .WIDTH (`UDRL_FIFO_WIDTH),
        .DEPTH (`UDRL_FIFO_DEPTH),
        .AW    (`UDRL_FIFO_AW)
    ) u_tx_fifo (
        .clk       (hclk),
        .rstn      (hresetn),
        .en        (ce),
        .flush     (tx_flush),
        .in_valid  (tx_push),
        .in_ready  (tx_in_ready),
        .in_data   (wr_data[7:0]),
        .out_valid (tx_out_valid),
        .out_ready (tx_out_ready),
        .out_data  (tx_out_data),
        .count     (tx_count)
    );

    // ============================================================
    // serial transmitter, 8 data bits, no parity, one stop bit
    reg         tx_state;
    reg  [9:0]  tx_shift;
    reg  [3:0]  tx_bits;
    reg  [15:0] baud_cnt;
    wire [15:0] bit_len = (divisor == 16'h0000) ? 16'h0001 : divisor;
    assign tx_out_ready = (tx_state == TX_IDLE);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_state        <= TX_IDLE;
            tx_shift        <= 10'h3FF;
            tx_bits         <= 4'h0;
            baud_cnt        <= 16'h0000;
            serial_line_out <= 1'b1;
        end else if (ce) begin
            case (tx_state)
                TX_IDLE: begin
                    serial_line_out <= 1'b1;
                    if (tx_out_valid) begin
                        tx_shift <= {1'b1, tx_out_data, 1'b0};
                        tx_bits  <= 4'h0;
                        baud_cnt <= 16'h0000;
                        tx_state <= TX_SHIFT;
                    end
                end
                TX_SHIFT: begin
                    serial_line_out <= tx_shift[0];
                    if (baud_cnt == bit_len - 16'h0001) begin
                        baud_cnt <= 16'h0000;
                        tx_shift <= {1'b1, tx_shift[9:1]};
                        if (tx_bits == 4'h9) begin
                            tx_state <= TX_IDLE;
                        end else begin
                            tx_bits <= tx_bits + 4'h1;
                        end
                    end else begin
                        baud_cnt <= baud_cnt + 16'h0001;
                    end
                end
                default: begin
                    tx_state <= TX_IDLE;
                end
            endcase
        end
    end
endmodule // udrl_top

/* hdl/udrl_unused_placeholder_removed.v */
`timescale 1ns/10ps

/* testbench/tb_uart_dma_ready_and_line_pins.sv */
`timescale 1ns/10ps
`include "udrl_defines.vh"
`define CHK(g, e, m) begin n_tests = n_tests + 1; if ((g) !== (e)) begin n_mismatch = n_mismatch + 1; $display("FAIL %0t %s", $time, m); end end
// ====================
// bench top
module tb_uart_dma_ready_and_line_pins;
    reg         hclk = 1'h0;
    reg         hresetn = 1'h0;
    reg  [7:0]  haddr = 8'h00;
    reg  [1:0]  htrans = 2'h0;
    reg         hwrite = 1'h0;
    reg  [31:0] hwdata = 32'h0;
    wire        hreadyout, hresp, far_hang;
    wire [31:0] hrdata;
    wire [7:0]  rx_char_data, pin_data;
    wire [2:0]  pin_addr;
    wire        rx_char_valid, rx_char_ready, pin_chip_select;
    wire        write_strobe_low_active_n, write_strobe_high_active;
    wire        serial_line_out, rts_n, rx_dma_request_n, tx_dma_request_n;
    wire [3:0]  mon = {hreadyout, serial_line_out, tx_dma_request_n, rx_dma_request_n};
    integer     n_mismatch = 0;
    integer     n_tests = 0;
    integer     i;
    reg  [31:0] d;
    always #2.5 hclk = ~hclk;
    udrl_top DUT (
        .hclk(hclk), .hresetn(hresetn), .ce(1'h1), .hsel(1'h1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .pin_chip_select(pin_chip_select),
        .write_strobe_low_active_n(write_strobe_low_active_n), .write_strobe_high_active(write_strobe_high_active),
        .pin_addr(pin_addr), .pin_data(pin_data), .rx_char_data(rx_char_data), .rx_char_valid(rx_char_valid),
        .rx_char_ready(rx_char_ready), .serial_line_in(1'h1), .serial_line_out(serial_line_out), .rts_n(rts_n),
        .rx_dma_request_n(rx_dma_request_n), .tx_dma_request_n(tx_dma_request_n)
    );
    udrl_far_end far (
        .hclk(hclk), .rx_char_ready(rx_char_ready), .rx_char_data(rx_char_data), .rx_char_valid(rx_char_valid),
        .pin_chip_select(pin_chip_select), .write_strobe_low_active_n(write_strobe_low_active_n),
        .write_strobe_high_active(write_strobe_high_active), .pin_addr(pin_addr), .pin_data(pin_data),
        .hang(far_hang)
    );
    task finish_test;
        begin
            $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
            if (n_mismatch == 0 && n_tests > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    // bounded wait for a monitored level
    task wait_sig(input integer s, input v, input integer lim);
        integer k;
        begin
            k = 0;
            @(posedge hclk);
            while (mon[s] !== v && k < lim) begin
                k = k + 1;
                @(posedge hclk);
            end
            if (k >= lim) begin
                `CHK(1'h0, 1'h1, "wait ran out")
                finish_test;
            end
        end
    endtask
    task ahb(input w, input [7:0] a, input [31:0] wd, output [31:0] rd);
        begin
            htrans <= 2'h2;
            haddr <= a;
            hwrite <= w;
            wait_sig(3, 1'h1, 5000);
            htrans <= 2'h0;
            hwdata <= wd;
            wait_sig(3, 1'h1, 5000);
            `CHK(hresp, 1'h0, "response not okay")
            rd = hrdata;
        end
    endtask
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        `CHK(serial_line_out, 1'h1, "line after reset")
        `CHK(rts_n, 1'h1, "rts after reset")
        `CHK(rx_dma_request_n, 1'h1, "rx req after reset")
        `CHK(tx_dma_request_n, 1'h0, "tx req after reset")
        $display("test reset done");
        // set, set with loop, set, loop only
        for (i = 0; i < 4; i = i + 1) begin
            ahb(1'h1, `UDRL_ADDR_MCTL, {27'h0, i[0], 2'h0, i != 3, 1'h0}, d);
            repeat (2) @(posedge hclk);
            `CHK(rts_n, i[0], "rts from bus")
        end
        ahb(1'h0, 8'h1C, 32'h0, d);
        `CHK(d, 32'h0, "unmapped read")
        far.pin_write(1'h0, 3'h2, 8'h02);
        repeat (2) @(posedge hclk);
        `CHK(rts_n, 1'h0, "pin write low strobe")
        far.pin_write(1'h1, 3'h2, 8'h00);
        repeat (2) @(posedge hclk);
        `CHK(rts_n, 1'h1, "pin write high strobe")
        $display("test rts done");
        for (i = 0; i < 2; i = i + 1) begin
            ahb(1'h1, `UDRL_ADDR_FCTL, i, d);
            far.send_char(8'h3C, 1);
            @(posedge hclk);
            `CHK(rx_dma_request_n, 1'h0, "single rx req")
            ahb(1'h0, `UDRL_ADDR_DATA, 32'h0, d);
            `CHK(d[7:0], 8'h3C, "single rx data")
            `CHK(rx_dma_request_n, 1'h1, "single rx req empty")
        end
        ahb(1'h1, `UDRL_ADDR_FCTL, 32'h49, d);
        for (i = 0; i < 16; i = i + 1) begin
            far.send_char(i[7:0], i % 2 + 1);
            repeat (2) @(posedge hclk);
            `CHK(rx_dma_request_n, i < 3, "multi rx trigger")
        end
        `CHK(rx_char_ready, 1'h0, "rx fifo full")
        for (i = 0; i < 16; i = i + 1) begin
            ahb(1'h0, `UDRL_ADDR_DATA, 32'h0, d);
            if (i == 15)
                @(posedge hclk);
            `CHK(d[7:0], i[7:0], "multi rx data")
            `CHK(rx_dma_request_n, i == 15, "multi rx req hold")
        end
        far.send_char(8'h55, 1);
        repeat (3900) @(posedge hclk);
        `CHK(rx_dma_request_n, 1'h1, "timeout too early")
        wait_sig(0, 1'h0, 300);
        ahb(1'h0, `UDRL_ADDR_DATA, 32'h0, d);
        `CHK(d[7:0], 8'h55, "timeout data")
        $display("test rx done");
        ahb(1'h1, `UDRL_ADDR_FCTL, 32'h0, d);
        ahb(1'h1, `UDRL_ADDR_DATA, 32'hA5, d);
        wait_sig(2, 1'h0, 400);
        d = 32'h1A5;
        repeat (8) @(posedge hclk);
        for (i = 0; i < 9; i = i + 1) begin
            repeat (`UDRL_DIV_RESET) @(posedge hclk);
            `CHK(serial_line_out, d[i], "serial bit")
        end
        `CHK(tx_dma_request_n, 1'h0, "single tx req empty")
        ahb(1'h1, `UDRL_ADDR_FCTL, 32'h09, d);
        for (i = 0; i < 18; i = i + 1) begin
            ahb(1'h1, `UDRL_ADDR_DATA, i, d);
            if (i == 16)
                repeat (2) @(posedge hclk);
            if (i == 16)
                `CHK(tx_dma_request_n, 1'h1, "multi tx full")
        end
        wait_sig(1, 1'h0, 3500);
        `CHK(far_hang, 1'h0, "char source stalled")
        $display("test tx done");
        finish_test;
    end
endmodule // tb_uart_dma_ready_and_line_pins

/* testbench/udrl_checker_assertions.sv */
`timescale 1ns/10ps
`include "udrl_defines.vh"
// ====================
// port checker
module udrl_checker (
    input wire        hclk,
    input wire        hresetn,
    input wire        ce,
    input wire        hsel,
    input wire [7:0]  haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [31:0] hwdata,
    input wire        hready,
    input wire        rx_char_valid,
    input wire        rx_char_ready,
    input wire        serial_line_out,
    input wire        rts_n,
    input wire        rx_dma_request_n,
    input wire        tx_dma_request_n
);
    reg       wr_ph;
    reg [7:0] ph_addr;
    reg       fifo_on;
    reg       dma_on;
    wire      done = wr_ph && hready && ce;
    wire      single = !(fifo_on && dma_on);
    wire      push = rx_char_valid && rx_char_ready && ce;
    wire      pop = hsel && htrans[1] && hready && ce && !hwrite && haddr == `UDRL_ADDR_DATA;
    wire      tx_wr = done && ph_addr == `UDRL_ADDR_DATA;
    // mode shadow follows bus writes only, pin writes to the fifo control are not tracked
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ph <= 1'h0;
            ph_addr <= 8'h00;
            fifo_on <= 1'h0;
            dma_on <= 1'h0;
        end else if (ce && hready) begin
            wr_ph <= hsel && htrans[1] && hwrite;
            ph_addr <= haddr;
            if (done && ph_addr == `UDRL_ADDR_FCTL) begin
                fifo_on <= hwdata[`UDRL_FCTL_FIFO_EN];
                dma_on <= hwdata[`UDRL_FCTL_DMA_MODE];
            end
        end
    end
    default clocking dc @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // ====================
    // assertions
    property p_rst_line;
        $rose(hresetn) |-> serial_line_out;
    endproperty
    a_rst_line: assert property (p_rst_line) else $error("line not marking");
    property p_rst_rts;
        $rose(hresetn) |-> rts_n;
    endproperty
    a_rst_rts: assert property (p_rst_rts) else $error("rts active after reset");
    property p_rts_write;
        done && ph_addr == `UDRL_ADDR_MCTL |-> ##2 rts_n == !($past(hwdata[1], 2) && !$past(hwdata[4], 2));
    endproperty
    a_rts_write: assert property (p_rts_write) else $error("rts does not follow control");
    property p_rx_push;
        single && push |=> !rx_dma_request_n;
    endproperty
    a_rx_push: assert property (p_rx_push) else $error("rx request not low on data");
    property p_rx_idle;
        single && $past(single) && rx_dma_request_n && !push |=> rx_dma_request_n;
    endproperty
    a_rx_idle: assert property (p_rx_idle) else $error("rx request low while empty");
    property p_rx_hold;
        (!single && !rx_dma_request_n && !pop) [*3] |=> !rx_dma_request_n;
    endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("rx request dropped early");
    property p_tx_write;
        single && tx_wr |=> tx_dma_request_n;
    endproperty
    a_tx_write: assert property (p_tx_write) else $error("tx request kept after write");
    property p_tx_stay;
        single && $past(single) && !tx_dma_request_n && !tx_wr |=> !tx_dma_request_n;
    endproperty
    a_tx_stay: assert property (p_tx_stay) else $error("tx request dropped unwritten");
endmodule // udrl_checker

bind udrl_top udrl_checker u_chk (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .rx_char_valid(rx_char_valid), .rx_char_ready(rx_char_ready),
    .serial_line_out(serial_line_out), .rts_n(rts_n), .rx_dma_request_n(rx_dma_request_n),
    .tx_dma_request_n(tx_dma_request_n)
);

/* testbench/udrl_far_end.sv */
`timescale 1ns/10ps
// ====================
// far side: character source and pin host
module udrl_far_end (
    input  wire       hclk,
    input  wire       rx_char_ready,
    output reg  [7:0] rx_char_data = 8'hFF,
    output reg        rx_char_valid = 1'h0,
    output reg        pin_chip_select = 1'h0,
    output reg        write_strobe_low_active_n = 1'h1,
    output reg        write_strobe_high_active = 1'h0,
    output reg  [2:0] pin_addr = 3'h7,
    output reg  [7:0] pin_data = 8'hFF,
    output reg        hang = 1'h0
);
    task send_char(input [7:0] d, input integer gap);
        integer k;
        begin
            repeat (gap) @(posedge hclk);
            rx_char_data <= d;
            rx_char_valid <= 1'h1;
            k = 0;
            @(posedge hclk);
            while (rx_char_ready !== 1'h1 && k < 400) begin
                k = k + 1;
                @(posedge hclk);
            end
            hang <= hang | (k >= 400);
            rx_char_valid <= 1'h0;
            rx_char_data <= ~d;
        end
    endtask
    // only one strobe moves, the other stays at its idle level
    task pin_write(input hi, input [2:0] a, input [7:0] d);
        begin
            pin_chip_select <= 1'h1;
            pin_addr <= a;
            pin_data <= d;
            repeat (2) @(posedge hclk);
            if (hi)
                write_strobe_high_active <= 1'h1;
            else
                write_strobe_low_active_n <= 1'h0;
            repeat (6) @(posedge hclk);
            write_strobe_high_active <= 1'h0;
            write_strobe_low_active_n <= 1'h1;
            repeat (6) @(posedge hclk);
            pin_chip_select <= 1'h0;
            pin_addr <= ~a;
            pin_data <= ~d;
        end
    endtask
endmodule // udrl_far_end
